// File: src/fsg_cfg.svh
// Constants for the flash section access guard
`ifndef FSG_CFG_SVH
`define FSG_CFG_SVH

// ----------------------------------------------------------------
// Address layout
// ----------------------------------------------------------------
`define FSG_WORD_W 12
`define FSG_PAGE_W 7
`define FSG_PAGE_LSB 5
// First page of the halting section; pages below it are read-while-write
`define FSG_HALT_FIRST_PAGE 7'h60

// ----------------------------------------------------------------
// Boot section start page for each boot_size_fuses code
// ----------------------------------------------------------------
`define FSG_BOOT_START_SZ0 7'h60
`define FSG_BOOT_START_SZ1 7'h70
`define FSG_BOOT_START_SZ2 7'h78
`define FSG_BOOT_START_SZ3 7'h7C

// ----------------------------------------------------------------
// Lock field values, high bit then low bit, 1 means unprogrammed
// ----------------------------------------------------------------
`define FSG_LOCK_UNPROG 2'h3
`define FSG_LOCK_HI_BIT 1
`define FSG_LOCK_LO_BIT 0

`endif

// File: src/fsg_pkg.sv
// Types shared by the flash section access guard
package fsg_pkg;

  // ----------------------------------------------------------------
  // Programming state, Gray coded along idle -> busy
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FSG_IDLE = 2'h0,
    FSG_LIVE_OP = 2'h1,
    FSG_HALT_OP = 2'h2
  } fsg_state_e;

  // Two-bit lock field: high bit, low bit
  typedef logic [1:0] fsg_lock_t;

endpackage

// File: src/fsg_lock_store.sv
// Holder for the application and boot lock fields
`include "fsg_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module fsg_lock_store (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // Stored values presented after reset
  input wire logic [3:0] i_nv_lock_bits,
  // Programming requests
  input wire logic i_sw_lock_set,
  input wire logic i_prog_lock_set,
  input wire logic [3:0] i_lock_data,
  input wire logic i_chip_erase,
  // Current fields
  output logic [1:0] o_application_lock_field,
  output logic [1:0] o_boot_lock_field
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [3:0] lock_r; // {boot field, application field}
  logic [3:0] lock_nxt;
  logic loaded_r; // Stored value already taken after reset
  logic set_any;

  // Either programming path may program bits
  assign set_any = i_sw_lock_set | i_prog_lock_set;

  // ----------------------------------------------------------------
  // Next value
  // ----------------------------------------------------------------
  always_comb begin
    lock_nxt = lock_r;
    if (!loaded_r) begin
      // Stored value taken once, after reset release
      lock_nxt = i_nv_lock_bits;
    end else if (i_chip_erase) begin
      // Only chip erase returns bits to unprogrammed
      lock_nxt = {`FSG_LOCK_UNPROG, `FSG_LOCK_UNPROG};
    end else if (set_any) begin
      // Programming can only clear bits, fields independent
      lock_nxt = lock_r & i_lock_data;
    end
  end

  // Register update
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lock_r <= 4'hF;
      loaded_r <= 1'b0;
    end else begin
      lock_r <= lock_nxt;
      loaded_r <= 1'b1;
    end
  end

  assign o_application_lock_field = lock_r[1:0];
  assign o_boot_lock_field = lock_r[3:2];

endmodule

`default_nettype wire

// File: src/fsg_guard.sv
// Flash section access guard: stall, busy flag and boot lock checks
//
// Overview of operation
// - Section of programmed page picks stall behaviour
// - Read-while-write page: core keeps running
// - Halting page: core stalled, nothing readable
// - Read-while-write section unreadable during programming unless a page load clears busy
// - Boot section always inside halting section
// - Busy flag reads one while section blocked by read-while-write programming
// - After read-while-write programming, blocked until software clears busy flag
// - Two independent lock fields, application and boot
// - Locks set by software or programmer; erase clears
// - General lock modes ignore program instructions
// - Application mode 1: no restriction
// - Application modes 2,3: refuse writes there
// - Application modes 3,4: refuse boot-side reads
// - Application modes 3,4: block interrupts conditionally
// - Boot mode 1: no restriction
// - Boot modes 2,3: refuse writes there
// - Boot modes 3,4: refuse application-side reads
// - Boot modes 3,4: block interrupts conditionally
// - Read enable while idle, or page load at any time, clears busy
// - Programming read-while-write page sets busy
`include "fsg_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module fsg_guard (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // Configuration
  input wire logic [1:0] i_boot_size_fuses,
  input wire logic i_vectors_in_boot,
  input wire logic [3:0] i_nv_lock_bits,
  // Core execution point
  input wire logic [`FSG_WORD_W-1:0] i_pc_addr,
  // Store program page operation request
  input wire logic i_pgop_req,
  input wire logic i_pgop_erase,
  input wire logic [`FSG_PAGE_W-1:0] i_pgop_page,
  input wire logic i_page_load,
  input wire logic i_section_read_enable,
  // Lock programming
  input wire logic i_sw_lock_set,
  input wire logic i_prog_lock_set,
  input wire logic [3:0] i_lock_data,
  input wire logic i_chip_erase,
  // Load program read request
  input wire logic i_ld_req,
  input wire logic [`FSG_WORD_W-1:0] i_ld_addr,
  // Instruction fetch observation
  input wire logic i_fetch_req,
  input wire logic [`FSG_WORD_W-1:0] i_fetch_addr,
  // Flash array handshake
  input wire logic i_flash_done,
  output logic o_flash_start,
  output logic o_flash_erase,
  output logic [`FSG_PAGE_W-1:0] o_flash_page,
  // Status towards the core
  output logic o_cpu_stall,
  output logic o_section_busy_flag,
  output logic o_live_read_block,
  output logic o_op_refused,
  output logic o_ld_grant,
  output logic o_ld_refused,
  output logic o_irq_block,
  output logic o_fetch_fault,
  output logic [1:0] o_application_lock_field,
  output logic [1:0] o_boot_lock_field
);

  // ----------------------------------------------------------------
  // Section decode functions
  // ----------------------------------------------------------------

  // Boot start page, clamped so boot never enters read-while-write
  function automatic logic [`FSG_PAGE_W-1:0] boot_start(
    input logic [1:0] sz
  );
    logic [`FSG_PAGE_W-1:0] p;
    case (sz)
      2'h0: p = `FSG_BOOT_START_SZ0;
      2'h1: p = `FSG_BOOT_START_SZ1;
      2'h2: p = `FSG_BOOT_START_SZ2;
      default: p = `FSG_BOOT_START_SZ3;
    endcase
    if (p < `FSG_HALT_FIRST_PAGE) begin
      p = `FSG_HALT_FIRST_PAGE;
    end
    return p;
  endfunction

  // Page lies in the read-while-write section
  function automatic logic page_is_live(
    input logic [`FSG_PAGE_W-1:0] pg
  );
    return pg < `FSG_HALT_FIRST_PAGE;
  endfunction

  // Page lies in the boot section
  function automatic logic page_is_boot(
    input logic [`FSG_PAGE_W-1:0] pg,
    input logic [1:0] sz
  );
    return pg >= boot_start(sz);
  endfunction

  // Page part of a word address
  function automatic logic [`FSG_PAGE_W-1:0] page_of(
    input logic [`FSG_WORD_W-1:0] a
  );
    return a[`FSG_WORD_W-1:`FSG_PAGE_LSB];
  endfunction

  // ----------------------------------------------------------------
  // Lock fields
  // ----------------------------------------------------------------
  fsg_pkg::fsg_lock_t app_lock; // Application lock field
  fsg_pkg::fsg_lock_t boot_lock; // Boot lock field

  fsg_lock_store u_lock (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_nv_lock_bits(i_nv_lock_bits),
    .i_sw_lock_set(i_sw_lock_set),
    .i_prog_lock_set(i_prog_lock_set),
    .i_lock_data(i_lock_data),
    .i_chip_erase(i_chip_erase),
    .o_application_lock_field(app_lock),
    .o_boot_lock_field(boot_lock)
  );

  assign o_application_lock_field = app_lock;
  assign o_boot_lock_field = boot_lock;

  // Programmed low bit forbids writes (modes 2 and 3)
  wire app_wr_lock = !app_lock[`FSG_LOCK_LO_BIT];
  wire boot_wr_lock = !boot_lock[`FSG_LOCK_LO_BIT];
  // Programmed high bit forbids cross reads (modes 3 and 4)
  wire app_rd_lock = !app_lock[`FSG_LOCK_HI_BIT];
  wire boot_rd_lock = !boot_lock[`FSG_LOCK_HI_BIT];

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  fsg_pkg::fsg_state_e state_r; // Programming state
  fsg_pkg::fsg_state_e state_nxt;
  logic busy_r; // Section busy flag
  logic busy_nxt;
  logic [`FSG_PAGE_W-1:0] page_r; // Page latched at start
  logic erase_r; // Operation kind latched at start
  logic start_r;
  logic refused_r;
  logic stall_r;
  logic block_r;
  logic ld_grant_r;
  logic ld_refused_r;
  logic irq_block_r;
  logic fetch_fault_r;

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  wire pc_in_boot = page_is_boot(page_of(i_pc_addr), i_boot_size_fuses);
  wire pgop_tgt_boot = page_is_boot(i_pgop_page, i_boot_size_fuses);
  wire pgop_tgt_live = page_is_live(i_pgop_page);
  wire idle = (state_r == fsg_pkg::FSG_IDLE);

  // Write lock of the targeted section; general lock modes are not
  // an input here, so they cannot gate program instructions
  wire pgop_locked = pgop_tgt_boot ? boot_wr_lock : app_wr_lock;

  // Page operations only start from boot code while idle
  wire pgop_refuse = i_pgop_req &&
    (pgop_locked || !pc_in_boot || !idle);
  wire pgop_accept = i_pgop_req && !pgop_refuse;

  // Read-while-write section is blocked while flag set or halted
  wire live_blocked = busy_r || (state_r == fsg_pkg::FSG_HALT_OP);

  // Load program read checks
  wire ld_tgt_boot = page_is_boot(page_of(i_ld_addr), i_boot_size_fuses);
  wire ld_tgt_live = page_is_live(page_of(i_ld_addr));
  wire ld_cross_app = pc_in_boot && !ld_tgt_boot && app_rd_lock;
  wire ld_cross_boot = !pc_in_boot && ld_tgt_boot && boot_rd_lock;
  wire ld_deny = ld_cross_app || ld_cross_boot ||
    (ld_tgt_live && live_blocked);

  // Interrupt blocking by vector placement and execution section
  wire irq_blk = (i_vectors_in_boot && !pc_in_boot && app_rd_lock) ||
    (!i_vectors_in_boot && pc_in_boot && boot_rd_lock);

  // Fetch into the blocked section is flagged to the core
  wire fetch_bad = i_fetch_req && live_blocked &&
    page_is_live(page_of(i_fetch_addr));

  // ----------------------------------------------------------------
  // State machine
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      fsg_pkg::FSG_IDLE: begin
        // Section of the target page chooses running or halting
        if (pgop_accept) begin
          state_nxt = pgop_tgt_live ? fsg_pkg::FSG_LIVE_OP
                                    : fsg_pkg::FSG_HALT_OP;
        end
      end
      fsg_pkg::FSG_LIVE_OP: begin
        if (i_flash_done) begin
          state_nxt = fsg_pkg::FSG_IDLE;
        end
      end
      fsg_pkg::FSG_HALT_OP: begin
        if (i_flash_done) begin
          state_nxt = fsg_pkg::FSG_IDLE;
        end
      end
      default: begin
        state_nxt = fsg_pkg::FSG_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Busy flag
  // ----------------------------------------------------------------
  // Clear only once idle; page load clears at any time
  wire busy_clr = (i_section_read_enable && idle) || i_page_load;
  wire busy_set = pgop_accept && pgop_tgt_live;

  // Set wins over a clear in the same cycle
  always_comb begin
    busy_nxt = busy_r;
    if (busy_set) begin
      busy_nxt = 1'b1;
    end else if (busy_clr) begin
      busy_nxt = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // State and latched operation
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r <= fsg_pkg::FSG_IDLE;
      busy_r <= 1'b0;
      page_r <= '0;
      erase_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      busy_r <= busy_nxt;
      // Page latched so later pointer use cannot move it
      if (pgop_accept) begin
        page_r <= i_pgop_page;
        erase_r <= i_pgop_erase;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      start_r <= 1'b0;
      refused_r <= 1'b0;
      stall_r <= 1'b0;
      block_r <= 1'b0;
      ld_grant_r <= 1'b0;
      ld_refused_r <= 1'b0;
      irq_block_r <= 1'b0;
      fetch_fault_r <= 1'b0;
    end else begin
      start_r <= pgop_accept;
      refused_r <= pgop_refuse;
      stall_r <= (state_nxt == fsg_pkg::FSG_HALT_OP);
      block_r <= busy_nxt || (state_nxt == fsg_pkg::FSG_HALT_OP);
      ld_grant_r <= i_ld_req && !ld_deny;
      ld_refused_r <= i_ld_req && ld_deny;
      irq_block_r <= irq_blk;
      fetch_fault_r <= fetch_bad;
    end
  end

  assign o_flash_start = start_r;
  assign o_flash_erase = erase_r;
  assign o_flash_page = page_r;
  assign o_cpu_stall = stall_r;
  assign o_section_busy_flag = busy_r;
  assign o_live_read_block = block_r;
  assign o_op_refused = refused_r;
  assign o_ld_grant = ld_grant_r;
  assign o_ld_refused = ld_refused_r;
  assign o_irq_block = irq_block_r;
  assign o_fetch_fault = fetch_fault_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);

  // Accepted start of a read-while-write page
  sequence s_live_start;
    pgop_accept && pgop_tgt_live;
  endsequence

  // Accepted start of a halting page
  sequence s_halt_start;
    pgop_accept && !pgop_tgt_live;
  endsequence

  property p_live_sets_busy;
    s_live_start |=> o_section_busy_flag && !o_cpu_stall && o_flash_start;
  endproperty
  a_live_sets_busy: assert property (p_live_sets_busy)
    else $error("busy flag not set by read-while-write start");

  property p_halt_stalls;
    s_halt_start |=> o_cpu_stall && o_live_read_block && o_flash_start;
  endproperty
  a_halt_stalls: assert property (p_halt_stalls)
    else $error("halting page start did not stall core");

  property p_stall_till_done;
    o_cpu_stall && !i_flash_done |=> o_cpu_stall;
  endproperty
  a_stall_till_done: assert property (p_stall_till_done)
    else $error("stall dropped before operation end");

  property p_busy_holds;
    o_section_busy_flag && !i_page_load && !i_section_read_enable
      |=> o_section_busy_flag;
  endproperty
  a_busy_holds: assert property (p_busy_holds)
    else $error("busy flag cleared without software action");

  property p_busy_clear;
    i_page_load && !busy_set |=> !o_section_busy_flag;
  endproperty
  a_busy_clear: assert property (p_busy_clear)
    else $error("page load did not clear busy flag");

  property p_app_write_lock;
    i_pgop_req && !pgop_tgt_boot && !app_lock[0]
      |=> o_op_refused && !o_flash_start && !o_cpu_stall;
  endproperty
  a_app_write_lock: assert property (p_app_write_lock)
    else $error("locked application write was not refused");

  property p_boot_write_lock;
    i_pgop_req && pgop_tgt_boot && !boot_lock[0]
      |=> o_op_refused && !o_flash_start;
  endproperty
  a_boot_write_lock: assert property (p_boot_write_lock)
    else $error("locked boot write was not refused");

  property p_ld_app_lock;
    i_ld_req && pc_in_boot && !ld_tgt_boot && !app_lock[1]
      |=> o_ld_refused && !o_ld_grant;
  endproperty
  a_ld_app_lock: assert property (p_ld_app_lock)
    else $error("locked application read was granted");

  property p_ld_boot_lock;
    i_ld_req && !pc_in_boot && ld_tgt_boot && !boot_lock[1]
      |=> o_ld_refused;
  endproperty
  a_ld_boot_lock: assert property (p_ld_boot_lock)
    else $error("locked boot read was granted");

  property p_ld_free;
    i_ld_req && app_lock == 2'h3 && boot_lock == 2'h3 && !live_blocked
      |=> o_ld_grant;
  endproperty
  a_ld_free: assert property (p_ld_free)
    else $error("unlocked read was refused");

  property p_irq_block;
    i_vectors_in_boot && !pc_in_boot && !app_lock[1] |=> o_irq_block;
  endproperty
  a_irq_block: assert property (p_irq_block)
    else $error("interrupt not blocked in application code");

  property p_irq_block_boot;
    !i_vectors_in_boot && pc_in_boot && !boot_lock[1] |=> o_irq_block;
  endproperty
  a_irq_block_boot: assert property (p_irq_block_boot)
    else $error("interrupt not blocked in boot code");

  property p_busy_blocks;
    o_section_busy_flag |-> o_live_read_block;
  endproperty
  a_busy_blocks: assert property (p_busy_blocks)
    else $error("busy flag set but section readable");

endmodule

`default_nettype wire

// File: tb/fsg_flash_model.sv
// Flash array stand-in that answers each start with one done pulse
`timescale 1ns/1ps
`default_nettype none

module fsg_flash_model (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // Busy time in cycles, set by the bench for prompt or slow answers
  input wire logic [3:0] i_busy_cycles,
  // Handshake with the guard
  input wire logic i_flash_start,
  output logic o_flash_done
);
  logic [3:0] cnt_r;  // Cycles left in the running operation

  // ----------------------------------------------------------------
  // Operation timer
  // ----------------------------------------------------------------
  // Done never comes in the cycle of start, as a real array cannot
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_r <= 4'h0;
      o_flash_done <= 1'b0;
    end else begin
      o_flash_done <= (cnt_r == 4'h1);
      if (i_flash_start) begin
        cnt_r <= i_busy_cycles;
      end else if (cnt_r != 4'h0) begin
        cnt_r <= cnt_r - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// File: tb/test_flash_section_access_guard.sv
// Self-checking bench for the flash section access guard
`timescale 1ns/1ps
`default_nettype none

module test_flash_section_access_guard;
  // ----------------------------------------------------------------
  // Bench signals
  // ----------------------------------------------------------------
  logic clk, rst_b, vib, erase, done;
  logic [1:0] fuses, app_f, boot_f;
  logic [3:0] nv, lock_data, busy_cyc;
  logic [11:0] pc, ld_addr, fetch_addr;
  logic [6:0] page, fpage;
  logic [7:0] strb;  // Request strobes, one bit per request kind
  logic start, ferase, stall, busy, block, refused, grant, ld_ref, irq, fault;
  int n_fail, check_count, cyc_count;

  // Clock at 40 MHz
  always #12.5 clk = ~clk;

  fsg_guard uut (
    .i_core_clk(clk), .i_rst_b(rst_b), .i_boot_size_fuses(fuses),
    .i_vectors_in_boot(vib), .i_nv_lock_bits(nv), .i_pc_addr(pc),
    .i_pgop_req(strb[0]), .i_pgop_erase(erase), .i_pgop_page(page),
    .i_page_load(strb[3]), .i_section_read_enable(strb[4]),
    .i_sw_lock_set(strb[5]), .i_prog_lock_set(strb[6]),
    .i_lock_data(lock_data), .i_chip_erase(strb[7]), .i_ld_req(strb[1]),
    .i_ld_addr(ld_addr), .i_fetch_req(strb[2]), .i_fetch_addr(fetch_addr),
    .i_flash_done(done), .o_flash_start(start), .o_flash_erase(ferase),
    .o_flash_page(fpage), .o_cpu_stall(stall), .o_section_busy_flag(busy),
    .o_live_read_block(block), .o_op_refused(refused), .o_ld_grant(grant),
    .o_ld_refused(ld_ref), .o_irq_block(irq), .o_fetch_fault(fault),
    .o_application_lock_field(app_f), .o_boot_lock_field(boot_f)
  );

  fsg_flash_model flash (
    .i_core_clk(clk), .i_rst_b(rst_b), .i_busy_cycles(busy_cyc),
    .i_flash_start(start), .o_flash_done(done)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] exp,
                     input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One-cycle strobe; outputs are settled when it returns
  task automatic pulse(input int k);
    @(posedge clk);
    strb[k] <= 1'b1;
    @(posedge clk);
    strb[k] <= 1'b0;
    #1;
  endtask

  // Page operation request
  task automatic pgop(input logic [6:0] pg, input logic er);
    @(posedge clk);
    page <= pg;
    erase <= er;
    pulse_hold(0);
  endtask

  // Load-program read request
  task automatic ld(input logic [11:0] a);
    @(posedge clk);
    ld_addr <= a;
    pulse_hold(1);
  endtask

  // Strobe raised at the edge the caller already waited for
  task automatic pulse_hold(input int k);
    strb[k] <= 1'b1;
    @(posedge clk);
    strb[k] <= 1'b0;
    #1;
  endtask

  // Bounded wait for the done pulse of the array
  task automatic wait_done;
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      #1;
      if (done === 1'b1) begin
        break;
      end
    end
    chk("flash_done", 8'h01, {7'h00, done});
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Hang guard, far above the length of the tests
  always @(posedge clk) begin
    cyc_count <= cyc_count + 1;
    if (cyc_count == 3000) begin
      n_fail++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 0; rst_b = 0; strb = 8'h00; fuses = 2'h0; nv = 4'hF;
    vib = 1; // Vectors kept in boot while programming
    pc = 12'hC00; page = 7'h00; erase = 0; ld_addr = 12'h000;
    fetch_addr = 12'h200; lock_data = 4'hF; busy_cyc = 4'hF;
    n_fail = 0; check_count = 0; cyc_count = 0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk("app_lock", 8'h03, {6'h00, app_f});
    chk("boot_lock", 8'h03, {6'h00, boot_f});
    $display("test reset done");
    // Slow write to a read-while-write page
    pgop(7'h10, 1'b0);
    chk("start", 8'h01, {7'h00, start});
    chk("page", 8'h10, {1'b0, fpage});
    chk("stall", 8'h00, {7'h00, stall});
    chk("busy", 8'h01, {7'h00, busy});
    chk("block", 8'h01, {7'h00, block});
    ld(12'hC20);
    chk("ld_grant", 8'h01, {7'h00, grant});
    ld(12'h200);
    chk("ld_refused", 8'h01, {7'h00, ld_ref});
    pulse(2);
    chk("fetch_fault", 8'h01, {7'h00, fault});
    pulse(4);
    chk("busy_kept", 8'h01, {7'h00, busy});
    pgop(7'h11, 1'b0);
    chk("refused", 8'h01, {7'h00, refused});
    chk("no_stall", 8'h00, {7'h00, stall});
    wait_done();
    repeat (2) @(posedge clk);
    #1;
    chk("busy_after", 8'h01, {7'h00, busy});
    chk("block_after", 8'h01, {7'h00, block});
    pulse(4); // Flag cleared before the next load read there
    chk("busy_clr", 8'h00, {7'h00, busy});
    chk("block_clr", 8'h00, {7'h00, block});
    ld(12'h200);
    chk("ld_grant2", 8'h01, {7'h00, grant});
    $display("test read-while-write done");
    // Halting-page erase under every boot size, prompt array
    for (int f = 0; f < 4; f++) begin
      @(posedge clk);
      fuses <= f[1:0];
      pc <= 12'hFE0;
      busy_cyc <= 4'h1;
      pgop(7'h7C, 1'b1);
      chk("stall", 8'h01, {7'h00, stall});
      chk("block", 8'h01, {7'h00, block});
      chk("erase", 8'h01, {7'h00, ferase});
      chk("busy_off", 8'h00, {7'h00, busy});
      wait_done();
      @(posedge clk);
      #1;
      chk("stall_end", 8'h00, {7'h00, stall});
    end
    @(posedge clk);
    pc <= 12'hC00;
    pgop(7'h10, 1'b0);
    chk("app_pc_refused", 8'h01, {7'h00, refused});
    @(posedge clk);
    fuses <= 2'h0;
    pgop(7'h20, 1'b0);
    wait_done();
    pulse(3);
    chk("busy_load_clr", 8'h00, {7'h00, busy});
    $display("test halting section done");
    // Application lock modes 2 and 3
    @(posedge clk);
    lock_data <= 4'b1110;
    pulse_hold(5);
    chk("app_lock", 8'h02, {6'h00, app_f});
    chk("boot_lock", 8'h03, {6'h00, boot_f});
    pgop(7'h10, 1'b0);
    chk("app_wr_refused", 8'h01, {7'h00, refused});
    ld(12'h200);
    chk("app_rd_grant", 8'h01, {7'h00, grant});
    @(posedge clk);
    lock_data <= 4'b1100;
    pulse_hold(6);
    chk("app_lock3", 8'h00, {6'h00, app_f});
    ld(12'h200);
    chk("app_rd_refused", 8'h01, {7'h00, ld_ref});
    @(posedge clk);
    pc <= 12'h100;
    repeat (2) @(posedge clk);
    #1;
    chk("irq_app", 8'h01, {7'h00, irq});
    pulse(7);
    chk("erase_app", 8'h03, {6'h00, app_f});
    $display("test application locks done");
    // Boot lock modes 4 and 3
    @(posedge clk);
    pc <= 12'hC00;
    lock_data <= 4'b0111;
    pulse_hold(5);
    chk("boot_lock4", 8'h01, {6'h00, boot_f});
    pgop(7'h70, 1'b1);
    chk("boot_wr_ok", 8'h01, {7'h00, start});
    wait_done();
    @(posedge clk);
    pc <= 12'h100;
    ld(12'hC00);
    chk("boot_rd_refused", 8'h01, {7'h00, ld_ref});
    @(posedge clk);
    vib <= 1'b0;
    pc <= 12'hC00;
    repeat (2) @(posedge clk);
    #1;
    chk("irq_boot", 8'h01, {7'h00, irq});
    @(posedge clk);
    lock_data <= 4'b0011;
    pulse_hold(5);
    chk("boot_lock3", 8'h00, {6'h00, boot_f});
    pgop(7'h70, 1'b1);
    chk("boot_wr_refused", 8'h01, {7'h00, refused});
    $display("test boot locks done");
    report_and_stop();
  end
endmodule
`default_nettype wire
